// [sim/sba_master.sv]
// bus master model: raises request, starts a frame on grant
module sba_master (
  input  wire logic mclk,
  input  wire logic want,
  input  wire logic start,
  input  wire logic gnt_l,
  output logic      req_l,
  output logic      frame_l
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] len;
  logic [2:0] next_len;
  initial begin
    req_l = 1'b1;
    frame_l = 1'b1;
    len = 3'h0;
  end
  assign next_len = (len != 3'h0) ? len - 3'h1 :
                    (!gnt_l && start && frame_l) ? 3'h4 : 3'h0;
  always @(posedge mclk) begin
    req_l <= ~want;
    len <= next_len;
    frame_l <= (next_len == 3'h0);
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench for the secondary bus arbiter
module tb_top;
  import sba_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  sba_cfg_t    cfg = '0;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;
  sba_pins_t   pins;
  logic [3:0]  gnt_l;
  logic        int_req = 1'b0;
  logic        want = 1'b0;
  logic        start = 1'b0;
  logic        req2_l = 1'b1;
  logic        m1_req_l;
  logic        frame_l;
  int          error_cnt = 0;
  int          compares = 0;
  int          n;
  always #10 mclk = ~mclk;
  assign pins = {2'b11, req2_l, m1_req_l, frame_l, 1'b1, 1'b1};
  sba_arbiter sba_arbiter_i (.mclk(mclk), .arst_n(arst_n), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .pins(pins),
    .gnt_l(gnt_l), .int_req(int_req), .int_gnt(), .ext_req_l());
  sba_master sba_master_i (.mclk(mclk), .want(want), .start(start),
    .gnt_l(gnt_l[0]), .req_l(m1_req_l), .frame_l(frame_l));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    cfg <= {w, ~w, a, 4'hF, d};
    @(posedge mclk);
    cfg <= '0;
    #1;
    chk("cfg_ack", 32'h1, {31'h0, cfg_ack});
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk("cfg_rdata", exp, cfg_rdata);
  endtask
  task automatic t_regs;
    rd(ARB_OFF, 32'h0040801F);
    acc(1'b1, ARB_OFF, 32'hFFFFFDFF);
    rd(ARB_OFF, 32'h07DFFC1F);
    acc(1'b1, ARB_OFF, 32'h0040801F);
    acc(1'b1, 8'h44, 32'hFFFFFFFF);
    rd(8'h44, 32'h0);
    acc(1'b1, PARK_OFF, 32'hFFFFFFFF);
    rd(PARK_OFF, 32'h1);
    acc(1'b1, PARK_OFF, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_grant;
    @(posedge mclk);
    want <= 1'b1;
    n = 0;
    while (gnt_l[0] !== 1'b0 && n < 12) begin
      cyc(1);
      n++;
    end
    chk("grant latency", 32'd4, n);
    @(posedge mclk);
    start <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      chk("grant held", 32'h0, {31'h0, gnt_l[0]});
    end
    $display("test grant done");
  endtask
  task automatic t_toggle;
    acc(1'b1, ARB_OFF, 32'h0050801F);
    cyc(6);
    n = 0;
    while (frame_l !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    while (frame_l !== 1'b0 && n < 16) begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk("gnt before gap", 32'h0, {31'h0, gnt_l[0]});
    cyc(1);
    chk("gnt gap", 32'h1, {31'h0, gnt_l[0]});
    cyc(1);
    chk("gnt after gap", 32'h0, {31'h0, gnt_l[0]});
    @(posedge mclk);
    start <= 1'b0;
    want <= 1'b0;
    $display("test toggle done");
  endtask
  task automatic t_broken;
    acc(1'b1, ARB_OFF, 32'h0040841F);
    cyc(8);
    @(posedge mclk);
    req2_l <= 1'b0;
    n = 0;
    while (gnt_l[1] !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("gnt master2", 32'h0, {31'h0, gnt_l[1]});
    n = 0;
    while (gnt_l[1] === 1'b0 && n < 30) begin
      cyc(1);
      n++;
    end
    chk("timeout span", 32'h1, {31'h0, n >= 15 && n <= 18});
    @(posedge mclk);
    req2_l <= 1'b1;
    cyc(2);
    @(posedge mclk);
    req2_l <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      chk("broken ignored", 32'h1, {31'h0, gnt_l[1]});
    end
    $display("test broken done");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_grant();
    t_toggle();
    t_broken();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
endmodule

// [src/sba_arbiter.sv]
// secondary bus arbiter: internal requester plus four bus masters
module sba_arbiter
  import sba_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire sba_cfg_t    cfg,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  input  wire sba_pins_t   pins,
  output logic      [3:0]  gnt_l,
  input  wire logic        int_req,
  output logic             int_gnt,
  output logic             ext_req_l
);

  function automatic logic [2:0] rr_pick(logic [5:0] m, logic [2:0] last);
    logic [2:0] r;
    logic       f;
    r = last;
    f = 1'b0;
    for (int k = 1; k <= 6; k++) begin
      if (!f && m[(int'(last) + k) % 6]) begin
        r = 3'((int'(last) + k) % 6);
        f = 1'b1;
      end
    end
    return r;
  endfunction
  sba_pins_t  pin_s1;
  sba_pins_t  pin_s2;
  logic       frame_d;
  logic [4:0] en;
  logic [4:0] pri;
  logic [7:0] fair;
  logic       ext_mode;
  logic       bm_en;
  logic       rfsh_en;
  logic       tog_en;
  logic       park_en;
  sba_state_t state;
  sba_state_t next_state;
  logic [4:0] g;
  logic [4:0] next_g;
  logic       new_grant;
  logic       rr_used;
  logic [4:0] brk;
  logic [4:0] gone;
  logic [4:0] served;
  logic [2:0] hptr;
  logic [2:0] lptr;
  logic [7:0] fc;
  logic       armed;
  logic [4:0] bmc;
  logic [1:0] tdly;
  // pin synchronisers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1  <= '1;
      pin_s2  <= '1;
      frame_d <= 1'b1;
    end else begin
      pin_s1  <= pins;
      pin_s2  <= pin_s1;
      frame_d <= pin_s2.frame_l;
    end
  end
  // configuration decode
  wire        arb_hit  = cfg.addr == ARB_OFF;
  wire        park_hit = cfg.addr == PARK_OFF;
  wire        wr_arb   = cfg.wr & arb_hit;
  wire        wr_park  = cfg.wr & park_hit;
  wire [31:0] arb_word = {5'h00, pri, 1'b0, tog_en, fair, rfsh_en,
                          bm_en, ext_mode, 4'h0, en};
  wire [31:0] rd_word  = arb_hit  ? arb_word :
                         park_hit ? {31'h0, park_en} : 32'h0;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en       <= EN_RST;
      pri      <= PRI_RST;
      fair     <= FAIR_RST;
      ext_mode <= 1'b0;
      bm_en    <= 1'b0;
      rfsh_en  <= 1'b0;
      tog_en   <= 1'b0;
      park_en  <= 1'b0;
    end else begin
      if (wr_arb && cfg.be[0])
        en <= cfg.wdata[4:0];
      if (wr_arb && cfg.be[1]) begin
        ext_mode  <= cfg.wdata[EXT_BIT];
        bm_en     <= cfg.wdata[BMTO_BIT];
        rfsh_en   <= cfg.wdata[RFSH_BIT];
        fair[3:0] <= cfg.wdata[FAIR_LSB +: 4];
      end
      if (wr_arb && cfg.be[2]) begin
        fair[7:4] <= cfg.wdata[FAIR_LSB + 4 +: 4];
        tog_en    <= cfg.wdata[TOG_BIT];
        pri[0]    <= cfg.wdata[PRI_LSB];
      end
      if (wr_arb && cfg.be[3])
        pri[4:1] <= cfg.wdata[PRI_LSB + 1 +: 4];
      if (wr_park && cfg.be[0])
        park_en <= cfg.wdata[0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_ack <= cfg.rd | cfg.wr;
      if (cfg.rd)
        cfg_rdata <= rd_word;
    end
  end

  // request qualification
  wire [4:0] req_v      = {~pin_s2.req_l, int_req};
  wire       bus_idle   = pin_s2.frame_l & pin_s2.irdy_l;
  wire       frame_fall = frame_d & ~pin_s2.frame_l;
  wire       granted    = |g;
  wire [4:0] excl       = brk & gone;
  wire       drop_brk   = |(g & excl);
  wire [4:0] elig       = req_v & en & ~excl & {5{~ext_mode}};
  wire       own_req    = |(g & elig);
  wire       others     = |(elig & ~g);
  wire [4:0] hi_m       = elig & pri;
  wire [4:0] lo_m       = elig & ~pri;
  wire [2:0] hsel       = rr_pick({|lo_m, hi_m}, hptr);
  wire [2:0] lsel       = rr_pick({1'b0, lo_m}, lptr);
  wire [2:0] pick       = (hsel == LOW_SLOT) ? lsel : hsel;
  wire [4:0] pick_oh    = 5'h01 << pick;
  wire       bm_run     = (state == ST_GRANT) & bm_en & bus_idle & own_req;
  wire       timeout    = bm_run & (bmc == BM_CYC - 5'h01);
  wire       fair_out   = others & ((fair == 8'h00) ? ~own_req :
                                    (armed & (fc == 8'h00)));
  wire       leave      = granted & (fair_out | (~own_req & others));
  wire       to_park    = park_en & ~others & ~own_req & ~g[0];
  wire       all_served = &(served | brk | ~en);
  wire       refresh    = rfsh_en & (|brk) & all_served;

  always_comb begin
    next_state = state;
    next_g     = g;
    new_grant  = 1'b0;
    rr_used    = 1'b0;
    case (state)
      ST_IDLE: begin
        if (others) begin
          next_g     = pick_oh;
          new_grant  = 1'b1;
          rr_used    = 1'b1;
          next_state = ST_GRANT;
        end else if (park_en) begin
          next_g     = PARK_OH;
          new_grant  = 1'b1;
          next_state = ST_GRANT;
        end
      end
      ST_GRANT, ST_BUSY: begin
        if (timeout || drop_brk) begin
          next_g     = 5'h00;
          next_state = ST_IDLE;
        end else if ((leave || to_park) && bus_idle) begin
          next_g     = to_park ? PARK_OH : pick_oh;
          new_grant  = 1'b1;
          rr_used    = ~to_park;
          next_state = ST_GRANT;
        end else if (leave) begin
          next_g     = 5'h00;
          next_state = ST_DROP;
        end else if (state == ST_GRANT && frame_fall) begin
          next_state = ST_BUSY;
        end else if (state == ST_BUSY && bus_idle) begin
          next_state = ST_GRANT;
        end
      end
      ST_DROP: begin
        if (bus_idle)
          next_state = ST_IDLE;
      end
      default: begin
        next_g     = 5'h00;
        next_state = ST_IDLE;
      end
    endcase
    if (ext_mode) begin
      next_g     = 5'h00;
      next_state = ST_IDLE;
      new_grant  = 1'b0;
      rr_used    = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      g     <= 5'h00;
      hptr  <= 3'h0;
      lptr  <= 3'h0;
    end else begin
      state <= next_state;
      g     <= next_g;
      if (rr_used)
        hptr <= hsel;
      if (rr_used && hsel == LOW_SLOT)
        lptr <= lsel;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fc    <= FAIR_RST;
      armed <= 1'b0;
    end else if (new_grant) begin
      fc    <= fair;
      armed <= 1'b0;
    end else begin
      if (granted && frame_fall)
        armed <= 1'b1;
      if (armed && others && fc != 8'h00)
        fc <= fc - 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      bmc <= 5'h00;
    else if (!bm_run || new_grant)
      bmc <= 5'h00;
    else
      bmc <= bmc + 5'h01;
  end

  // per-requester broken tracking
  for (genvar i = 0; i < NREQ; i++) begin : g_req
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        brk[i]    <= 1'b0;
        gone[i]   <= 1'b0;
        served[i] <= 1'b0;
      end else begin
        if (timeout && g[i])
          brk[i] <= 1'b1;
        else if (refresh)
          brk[i] <= 1'b0;
        if (timeout && g[i])
          gone[i] <= 1'b0;
        else if (brk[i] && !req_v[i])
          gone[i] <= 1'b1;
        else if (refresh)
          gone[i] <= 1'b0;
        if (timeout || refresh)
          served[i] <= 1'b0;
        else if (new_grant && next_g[i])
          served[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      tdly <= 2'b00;
    else
      tdly <= {tdly[0], frame_fall & granted & tog_en};
  end

  wire       hole = tdly[1];
  wire [4:0] gout = g & ~{5{hole}};

  assign gnt_l     = ~gout[4:1];
  assign int_gnt   = ext_mode ? ~pin_s2.ext_gnt_l : gout[0];
  assign ext_req_l = ~(ext_mode & int_req);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  one_grant_a: assert property ($onehot0(g))
    else $error("more than one grant");
  bm_expire_a: assert property (
    timeout |-> $past(bm_run, 15) && $past(bm_run, 1))
    else $error("broken timer expired early");
  bm_withdraw_a: assert property (
    timeout |=> g == 5'h00 && (brk & $past(g)) != 5'h00)
    else $error("broken master kept grant");
  fair_reload_a: assert property (
    new_grant && !ext_mode |=> fc == $past(fair) && !armed)
    else $error("fairness not reloaded");
  fair_wait_a: assert property (
    !armed && !new_grant |=> fc == $past(fc))
    else $error("fairness moved before frame");
  fair_zero_a: assert property (
    fair == 8'h00 && own_req && !timeout && !ext_mode |=> g == $past(g))
    else $error("grant dropped while requested");
  gap_time_a: assert property (
    granted && frame_fall && tog_en |-> ##2 hole ##1 !hole)
    else $error("grant gap misplaced");
  no_gap_a: assert property (
    hole |-> $past(tog_en, 2))
    else $error("grant gap while toggle off");
  rsvd_read_a: assert property (
    cfg.rd && arb_hit |=> cfg_rdata[31:27] == 5'h00 && !cfg_rdata[21])
    else $error("reserved bits not zero");
  excl_grant_a: assert property (
    new_grant && rr_used |-> (next_g & excl) == 5'h00)
    else $error("excluded master granted");

  grant_c:   cover property (state == ST_IDLE ##1 state == ST_GRANT);
  timeout_c: cover property (timeout);
  gap_c:     cover property (hole);
  preempt_c: cover property (state == ST_BUSY ##1 state == ST_DROP);
endmodule

// [src/sba_pkg.sv]
// constants and carrier types of the secondary bus arbiter
package sba_pkg;
  localparam int         NREQ      = 5;
  localparam logic [7:0] ARB_OFF   = 8'h48;
  localparam logic [7:0] PARK_OFF  = 8'h40;
  localparam int         EXT_BIT   = 9;
  localparam int         BMTO_BIT  = 10;
  localparam int         RFSH_BIT  = 11;
  localparam int         FAIR_LSB  = 12;
  localparam int         TOG_BIT   = 20;
  localparam int         PRI_LSB   = 22;
  localparam logic [4:0] EN_RST    = 5'h1F;
  localparam logic [7:0] FAIR_RST  = 8'h08;
  localparam logic [4:0] PRI_RST   = 5'h01;
  localparam logic [4:0] BM_CYC    = 5'h10;
  localparam logic [2:0] LOW_SLOT  = 3'h5;
  localparam logic [4:0] PARK_OH   = 5'h01;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_GRANT = 2'b01,
    ST_BUSY  = 2'b10,
    ST_DROP  = 2'b11
  } sba_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } sba_cfg_t;

  typedef struct packed {
    logic [3:0] req_l;
    logic       frame_l;
    logic       irdy_l;
    logic       ext_gnt_l;
  } sba_pins_t;
endpackage
